// ---- pfr_regs.svh ----
// Register indices, field positions, reset values and bus codes for the
// peripheral interrupt flag block. Assumes AXI4-Lite with 32-bit data,
// register index times four as the byte address.
// Functional notes
// R1 - Each flag sets on its event regardless of any enable bit.
// R2 - Software should clear flags before enabling the matching interrupt.
// R3 - Generator parameter flags are read-only, set while any source bit is set.
// R4 - Serial port 1 summary flag is read-only, clears when general sources clear.
// R5 - Serial port 1 framing error flag is read-only, clears when error sources clear.
// R6 - Serial port 1 transmit and receive flags follow the port; writes ignored.
// R7 - Serial peripheral port 2 summary flag is read-only, clears when sources clear.
// R8 - Serial peripheral port 2 transmit and receive flags ignore software writes.
// R9 - Serial peripheral port 1 summary flag is source OR; its transmit and receive read-only.
// R10 - Period and timer 3 flags are hardware-set, sticky, cleared by writing zero.
// R11 - Group 4 at 0x4b2: gen1 param, gen1 period, bits 5:4 empty, serial 1.
// R12 - Group 5 at 0x4b3: gen2 flags, timer 3 flags, bit 3 empty, port 2.
// R13 - Group 6 at 0x4b4: channel 2, oscillator, wavegen, logic cell 2, ext irq 1.
// R14 - Channel 2 abort flag rises on abort and holds until software clears it.
// R15 - Every implemented flag bit resets to zero.
// R16 - Read-only summary flags are the registered OR of their source bits.
`ifndef PFR_REGS_SVH
`define PFR_REGS_SVH

`define PFR_IDX_W 12
`define PFR_IDX_FLAGS4 12'h4b2
`define PFR_IDX_FLAGS5 12'h4b3
`define PFR_IDX_FLAGS6 12'h4b4
`define PFR_IDX_SPORT1 12'h4c0
`define PFR_IDX_MASK4 12'h4c1
`define PFR_IDX_MASK5 12'h4c2
`define PFR_IDX_MASK6 12'h4c3

`define PFR_F4_GEN1_PARAM 7
`define PFR_F4_GEN1_PERIOD 6
`define PFR_F4_SER1_SUM 3
`define PFR_F4_SER1_FERR 2
`define PFR_F4_SER1_TX 1
`define PFR_F4_SER1_RX 0
`define PFR_F5_GEN2_PARAM 7
`define PFR_F5_GEN2_PERIOD 6
`define PFR_F5_TMR3_GATE 5
`define PFR_F5_TMR3_OVF 4
`define PFR_F5_SP2_SUM 2
`define PFR_F5_SP2_TX 1
`define PFR_F5_SP2_RX 0
`define PFR_F6_CH2_ABORT 7
`define PFR_F6_CH2_OVR 6
`define PFR_F6_CH2_DCNT 5
`define PFR_F6_CH2_SCNT 4
`define PFR_F6_OSC1 3
`define PFR_F6_WAVEGEN1 2
`define PFR_F6_LCELL2 1
`define PFR_F6_EXT1 0
`define PFR_SP1_SUM 2
`define PFR_SP1_TX 1
`define PFR_SP1_RX 0

`define PFR_FLAG_RST 8'h00
`define PFR_MASK_RST 8'h00
`define PFR_F4_SW_CLR 8'h40
`define PFR_F5_SW_CLR 8'h70
`define PFR_F6_SW_CLR 8'hff

`define PFR_RESP_OKAY 2'h0
`define PFR_RESP_SLVERR 2'h2

`endif

// ---- pfr_pkg.sv ----
// Types shared by the peripheral interrupt flag block.
// Assumes the peripherals deliver events as one-cycle pulses in this clock.
`default_nettype none
package pfr_pkg;
    // One-cycle event pulses from the peripherals
    typedef struct packed {
        logic gen1_period;
        logic gen2_period;
        logic timer3_gate;
        logic timer3_ovf;
        logic chan2_abort;
        logic chan2_overrun;
        logic chan2_dest_count;
        logic chan2_src_count;
        logic osc1;
        logic wavegen1;
        logic logic_cell2;
        logic ext_irq1;
    } pfr_evt_t;

    // Buffer state levels of the serial ports
    typedef struct packed {
        logic serial1_tx;
        logic serial1_rx;
        logic sport2_tx;
        logic sport2_rx;
        logic sport1_tx;
        logic sport1_rx;
    } pfr_lvl_t;
endpackage
`default_nettype wire

// ---- pfr_flags.sv ----
// Peripheral interrupt flag registers with an AXI4-Lite slave port.
// Assumes inputs are synchronous to clock and events are one-cycle pulses.
//
// Register access over AXI4-Lite was chosen for this implementation.
`include "pfr_regs.svh"
`default_nettype none
module pfr_flags #(
    parameter int ADDR_W = 16,
    parameter int GEN_SRC_W = 8,
    parameter int SER_SRC_W = 8,
    parameter int SP_SRC_W = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pfr_pkg::pfr_evt_t evt,
    input wire pfr_pkg::pfr_lvl_t lvl,
    input wire logic [GEN_SRC_W-1:0] gen1_irq_sources,
    input wire logic [GEN_SRC_W-1:0] gen2_irq_sources,
    input wire logic [SER_SRC_W-1:0] serial1_general_sources,
    input wire logic [SER_SRC_W-1:0] serial1_error_sources,
    input wire logic [SP_SRC_W-1:0] sport2_irq_sources,
    input wire logic [SP_SRC_W-1:0] sport1_irq_sources,
    output logic irq
);
    import pfr_pkg::*;

    typedef struct packed {
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] flags4;
        logic [7:0] flags5;
        logic [7:0] flags6;
        logic [2:0] sport1;
        logic [7:0] mask4;
        logic [7:0] mask5;
        logic [7:0] mask6;
        logic irq;
    } pfr_state_t;

    // Indices up to 0x4c3 need byte address bits 13:0 plus a zero check above
    if (ADDR_W < 15 || ADDR_W > 32 || GEN_SRC_W < 1 || SER_SRC_W < 1 || SP_SRC_W < 1) begin : g_bad
        $error("pfr_flags: unsupported parameter values");
    end

    pfr_state_t st_q;
    pfr_state_t st_d;
    logic wr_fire;
    logic [`PFR_IDX_W-1:0] wr_idx;
    logic wr_ok;
    logic [7:0] clr4;
    logic [7:0] clr5;
    logic [7:0] clr6;
    logic [7:0] set4;
    logic [7:0] set5;
    logic [7:0] set6;
    logic [`PFR_IDX_W-1:0] rd_idx;
    logic rd_ok;

    function automatic logic [`PFR_IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] a);
        reg_index = a[`PFR_IDX_W+1:2];
    endfunction

    function automatic logic addr_in_range(input logic [ADDR_W-1:0] a);
        addr_in_range = (a[ADDR_W-1:`PFR_IDX_W+2] == '0);
    endfunction

    // Clear mask for a sticky flag group: a written zero clears writable bits
    function automatic logic [7:0] zero_clear(input logic hit, input logic [7:0] data,
                                              input logic [7:0] sw_bits);
        zero_clear = hit ? (sw_bits & ~data) : 8'h00;
    endfunction

    always_comb begin
        st_d = st_q;
        wr_fire = st_q.aw_held && st_q.w_held && !st_q.bvalid;
        wr_idx = reg_index(st_q.aw_addr);
        wr_ok = addr_in_range(st_q.aw_addr) && (wr_idx == `PFR_IDX_FLAGS4
            || wr_idx == `PFR_IDX_FLAGS5 || wr_idx == `PFR_IDX_FLAGS6
            || wr_idx == `PFR_IDX_SPORT1 || wr_idx == `PFR_IDX_MASK4
            || wr_idx == `PFR_IDX_MASK5 || wr_idx == `PFR_IDX_MASK6);
        rd_idx = reg_index(s_axi_araddr);
        rd_ok = 1'b0;

        // Address and data channels are taken independently, in either order
        if (s_axi_awvalid && !st_q.aw_held) begin
            st_d.aw_held = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.w_held) begin
            st_d.w_held = 1'b1;
            st_d.w_data = s_axi_wdata[7:0];
            st_d.w_lane0 = s_axi_wstrb[0];
        end

        clr4 = zero_clear(wr_fire && wr_ok && st_q.w_lane0 && wr_idx == `PFR_IDX_FLAGS4,
                          st_q.w_data, `PFR_F4_SW_CLR); // R10
        clr5 = zero_clear(wr_fire && wr_ok && st_q.w_lane0 && wr_idx == `PFR_IDX_FLAGS5,
                          st_q.w_data, `PFR_F5_SW_CLR); // R10
        clr6 = zero_clear(wr_fire && wr_ok && st_q.w_lane0 && wr_idx == `PFR_IDX_FLAGS6,
                          st_q.w_data, `PFR_F6_SW_CLR); // R10

        if (wr_fire) begin
            st_d.aw_held = 1'b0;
            st_d.w_held = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = wr_ok ? `PFR_RESP_OKAY : `PFR_RESP_SLVERR;
            if (wr_ok && st_q.w_lane0) begin
                if (wr_idx == `PFR_IDX_MASK4) begin
                    st_d.mask4 = st_q.w_data;
                end else if (wr_idx == `PFR_IDX_MASK5) begin
                    st_d.mask5 = st_q.w_data;
                end else if (wr_idx == `PFR_IDX_MASK6) begin
                    st_d.mask6 = st_q.w_data;
                end
            end
        end else if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end

        // Event sets, independent of any enable bit
        set4 = 8'h00; // R1
        set4[`PFR_F4_GEN1_PERIOD] = evt.gen1_period; // R1
        set5 = 8'h00;
        set5[`PFR_F5_GEN2_PERIOD] = evt.gen2_period; // R10
        set5[`PFR_F5_TMR3_GATE] = evt.timer3_gate; // R10
        set5[`PFR_F5_TMR3_OVF] = evt.timer3_ovf; // R10
        set6 = {evt.chan2_abort, evt.chan2_overrun, evt.chan2_dest_count, // R14
                evt.chan2_src_count, evt.osc1, evt.wavegen1, evt.logic_cell2, // R13
                evt.ext_irq1};

        // Set wins over a clear in the same cycle
        st_d.flags4 = (st_q.flags4 & ~clr4) | set4; // R10
        st_d.flags5 = (st_q.flags5 & ~clr5) | set5; // R10
        st_d.flags6 = (st_q.flags6 & ~clr6) | set6; // R14

        // Read-only bits track the peripherals one clock later; writes never touch them
        st_d.flags4[`PFR_F4_GEN1_PARAM] = |gen1_irq_sources; // R3
        st_d.flags4[5:4] = 2'b00; // R11
        st_d.flags4[`PFR_F4_SER1_SUM] = |serial1_general_sources; // R4
        st_d.flags4[`PFR_F4_SER1_FERR] = |serial1_error_sources; // R5
        st_d.flags4[`PFR_F4_SER1_TX] = lvl.serial1_tx; // R6
        st_d.flags4[`PFR_F4_SER1_RX] = lvl.serial1_rx; // R6
        st_d.flags5[`PFR_F5_GEN2_PARAM] = |gen2_irq_sources; // R3
        st_d.flags5[3] = 1'b0; // R12
        st_d.flags5[`PFR_F5_SP2_SUM] = |sport2_irq_sources; // R7
        st_d.flags5[`PFR_F5_SP2_TX] = lvl.sport2_tx; // R8
        st_d.flags5[`PFR_F5_SP2_RX] = lvl.sport2_rx; // R8
        st_d.sport1[`PFR_SP1_SUM] = |sport1_irq_sources; // R16
        st_d.sport1[`PFR_SP1_TX] = lvl.sport1_tx; // R9
        st_d.sport1[`PFR_SP1_RX] = lvl.sport1_rx; // R9

        // Read channel: one read in flight, data sampled at the accept edge
        if (s_axi_arvalid && !st_q.rvalid) begin
            st_d.rvalid = 1'b1;
            st_d.rdata = 32'h0000_0000;
            rd_ok = addr_in_range(s_axi_araddr);
            if (rd_idx == `PFR_IDX_FLAGS4) begin
                st_d.rdata[7:0] = st_q.flags4; // R11
            end else if (rd_idx == `PFR_IDX_FLAGS5) begin
                st_d.rdata[7:0] = st_q.flags5; // R12
            end else if (rd_idx == `PFR_IDX_FLAGS6) begin
                st_d.rdata[7:0] = st_q.flags6; // R13
            end else if (rd_idx == `PFR_IDX_SPORT1) begin
                st_d.rdata[2:0] = st_q.sport1;
            end else if (rd_idx == `PFR_IDX_MASK4) begin
                st_d.rdata[7:0] = st_q.mask4;
            end else if (rd_idx == `PFR_IDX_MASK5) begin
                st_d.rdata[7:0] = st_q.mask5;
            end else if (rd_idx == `PFR_IDX_MASK6) begin
                st_d.rdata[7:0] = st_q.mask6;
            end else begin
                rd_ok = 1'b0;
            end
            if (!rd_ok) begin
                st_d.rdata = 32'h0000_0000;
            end
            st_d.rresp = rd_ok ? `PFR_RESP_OKAY : `PFR_RESP_SLVERR;
        end else if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end

        // Computed from next values so the output stays a plain flop
        st_d.irq = |({st_d.flags4, st_d.flags5, st_d.flags6}
                     & {st_d.mask4, st_d.mask5, st_d.mask6});
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
            st_q.flags4 <= `PFR_FLAG_RST; // R15
            st_q.flags5 <= `PFR_FLAG_RST; // R15
            st_q.flags6 <= `PFR_FLAG_RST; // R15
            st_q.mask4 <= `PFR_MASK_RST;
            st_q.mask5 <= `PFR_MASK_RST;
            st_q.mask6 <= `PFR_MASK_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign s_axi_awready = !st_q.aw_held;
    assign s_axi_wready = !st_q.w_held;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = !st_q.rvalid;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;
    assign irq = st_q.irq;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    sequence s_flag6_zero_write;
        wr_fire && wr_ok && st_q.w_lane0 && wr_idx == `PFR_IDX_FLAGS6
            && !st_q.w_data[`PFR_F6_CH2_ABORT];
    endsequence

    sequence s_write_done;
        wr_fire ##1 st_q.bvalid;
    endsequence

    property p_evt_sets;
        evt.timer3_ovf || evt.ext_irq1 |=>
            (st_q.flags5[`PFR_F5_TMR3_OVF] || !$past(evt.timer3_ovf))
            && (st_q.flags6[`PFR_F6_EXT1] || !$past(evt.ext_irq1));
    endproperty
    a_evt_sets: assert property (p_evt_sets) else $error("event did not set flag"); // R1

    property p_gen_param;
        ##1 st_q.flags4[`PFR_F4_GEN1_PARAM] == $past(|gen1_irq_sources)
            && st_q.flags5[`PFR_F5_GEN2_PARAM] == $past(|gen2_irq_sources);
    endproperty
    a_gen_param: assert property (p_gen_param) else $error("parameter flag wrong"); // R3

    property p_ser1_sum;
        ##1 st_q.flags4[`PFR_F4_SER1_SUM] == $past(|serial1_general_sources);
    endproperty
    a_ser1_sum: assert property (p_ser1_sum) else $error("serial1 summary wrong"); // R4

    property p_ser1_ferr;
        !(|serial1_error_sources) |=> !st_q.flags4[`PFR_F4_SER1_FERR];
    endproperty
    a_ser1_ferr: assert property (p_ser1_ferr) else $error("framing flag stuck"); // R5

    property p_ser1_txrx;
        ##1 st_q.flags4[1:0] == $past({lvl.serial1_tx, lvl.serial1_rx});
    endproperty
    a_ser1_txrx: assert property (p_ser1_txrx) else $error("serial1 tx/rx wrong"); // R6

    property p_sp2;
        ##1 st_q.flags5[2:0] == $past({|sport2_irq_sources, lvl.sport2_tx, lvl.sport2_rx});
    endproperty
    a_sp2: assert property (p_sp2) else $error("sport2 flags wrong"); // R7

    property p_sp1;
        ##1 st_q.sport1 == $past({|sport1_irq_sources, lvl.sport1_tx, lvl.sport1_rx});
    endproperty
    a_sp1: assert property (p_sp1) else $error("sport1 flags wrong"); // R9

    property p_zero_clears;
        s_flag6_zero_write ##0 !evt.chan2_abort |=> !st_q.flags6[`PFR_F6_CH2_ABORT];
    endproperty
    a_zero_clears: assert property (p_zero_clears) else $error("zero write no clear"); // R10

    property p_abort_holds;
        st_q.flags6[`PFR_F6_CH2_ABORT] && !(wr_fire && wr_idx == `PFR_IDX_FLAGS6)
            |=> st_q.flags6[`PFR_F6_CH2_ABORT];
    endproperty
    a_abort_holds: assert property (p_abort_holds) else $error("abort flag dropped"); // R14

    property p_unimpl_zero;
        st_q.flags4[5:4] == 2'b00 && !st_q.flags5[3];
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set"); // R11

    property p_write_answer;
        s_write_done |-> st_q.bvalid && !st_q.aw_held && !st_q.w_held
            && st_q.bresp == ($past(wr_ok) ? `PFR_RESP_OKAY : `PFR_RESP_SLVERR);
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write not answered");

    property p_irq_level;
        irq == |({st_q.flags4, st_q.flags5, st_q.flags6} & {st_q.mask4, st_q.mask5, st_q.mask6});
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq mismatch");

    sequence s_read_take;
        s_axi_arvalid && !st_q.rvalid;
    endsequence

    property p_bresp_stands;
        st_q.bvalid && !s_axi_bready |=> st_q.bvalid && $stable(st_q.bresp);
    endproperty
    a_bresp_stands: assert property (p_bresp_stands) else $error("write response dropped");

    property p_rdata_stands;
        st_q.rvalid && !s_axi_rready
            |=> st_q.rvalid && $stable(st_q.rdata) && $stable(st_q.rresp);
    endproperty
    a_rdata_stands: assert property (p_rdata_stands) else $error("read data dropped");

    property p_read_refused;
        s_read_take ##0 !rd_ok
            |=> st_q.rresp == `PFR_RESP_SLVERR && st_q.rdata == 32'h0000_0000;
    endproperty
    a_read_refused: assert property (p_read_refused) else $error("unmapped read answered");

    property p_period_sticky;
        st_q.flags4[`PFR_F4_GEN1_PERIOD] && !(wr_fire && wr_idx == `PFR_IDX_FLAGS4)
            |=> st_q.flags4[`PFR_F4_GEN1_PERIOD];
    endproperty
    a_period_sticky: assert property (p_period_sticky) else $error("period flag dropped"); // R10

    property p_timer3_sticky;
        !(wr_fire && wr_idx == `PFR_IDX_FLAGS5)
            |=> (st_q.flags5[6:4] & $past(st_q.flags5[6:4])) == $past(st_q.flags5[6:4]);
    endproperty
    a_timer3_sticky: assert property (p_timer3_sticky) else $error("group5 flag dropped"); // R10

    property p_group6_sticky;
        !(wr_fire && wr_idx == `PFR_IDX_FLAGS6)
            |=> (st_q.flags6 & $past(st_q.flags6)) == $past(st_q.flags6);
    endproperty
    a_group6_sticky: assert property (p_group6_sticky) else $error("group6 flag dropped"); // R13

    property p_set_wins;
        wr_fire && wr_idx == `PFR_IDX_FLAGS5 && evt.timer3_gate
            |=> st_q.flags5[`PFR_F5_TMR3_GATE];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat event"); // R1

    property p_gen1_zero_clear;
        wr_fire && wr_ok && st_q.w_lane0 && wr_idx == `PFR_IDX_FLAGS4
            && !st_q.w_data[`PFR_F4_GEN1_PERIOD] && !evt.gen1_period
            |=> !st_q.flags4[`PFR_F4_GEN1_PERIOD];
    endproperty
    a_gen1_zero_clear: assert property (p_gen1_zero_clear) else $error("period not cleared"); // R10

    property p_mask_write;
        wr_fire && wr_ok && st_q.w_lane0 && wr_idx == `PFR_IDX_MASK6
            |=> st_q.mask6 == $past(st_q.w_data);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write lost");

    property p_write_no_effect;
        wr_fire && !(wr_ok && st_q.w_lane0)
            |=> $stable({st_q.mask4, st_q.mask5, st_q.mask6});
    endproperty
    a_write_no_effect: assert property (p_write_no_effect) else $error("refused write landed");
endmodule
`default_nettype wire

// ---- pfr_periph_model.sv ----
// Behavioural model of the peripherals that feed the interrupt flag block.
// Assumes the bench calls its tasks just after a rising clock edge.
`default_nettype none
module pfr_periph_model #(
    parameter int GW = 8,
    parameter int SW = 8,
    parameter int PW = 8
) (
    input wire logic clock,
    output var pfr_pkg::pfr_evt_t evt,
    output var pfr_pkg::pfr_lvl_t lvl,
    output var logic [GW-1:0] gen1_src,
    output var logic [GW-1:0] gen2_src,
    output var logic [SW-1:0] ser1_gen,
    output var logic [SW-1:0] ser1_err,
    output var logic [PW-1:0] sp2_src,
    output var logic [PW-1:0] sp1_src
);
    timeunit 1ns;
    timeprecision 1ns;
    import pfr_pkg::*;

    initial begin
        evt = '0;
        lvl = '0;
        {gen1_src, gen2_src, ser1_gen, ser1_err, sp2_src, sp1_src} = '0;
    end

    // Events last exactly one cycle; a held level would re-set flags every cycle
    task automatic pulse(input pfr_evt_t e);
        evt <= e;
        @(posedge clock);
        evt <= '0;
    endtask

    // Source bits are levels that persist until the peripheral drops them
    task automatic set_src(input logic [7:0] g1, input logic [7:0] g2, input logic [7:0] sg,
                           input logic [7:0] se, input logic [7:0] p2, input logic [7:0] p1,
                           input pfr_lvl_t l);
        gen1_src <= GW'(g1);
        gen2_src <= GW'(g2);
        ser1_gen <= SW'(sg);
        ser1_err <= SW'(se);
        sp2_src <= PW'(p2);
        sp1_src <= PW'(p1);
        lvl <= l;
    endtask
endmodule
`default_nettype wire

// ---- tb_peripheral_irq_flag_regs.sv ----
// Self-checking bench for the interrupt flag block over AXI4-Lite.
// Assumes the peripheral model drives every event and source input.
`include "pfr_regs.svh"
`default_nettype none
module tb_peripheral_irq_flag_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import pfr_pkg::*;

    localparam logic [1:0] OK = `PFR_RESP_OKAY;
    localparam logic [1:0] ERR = `PFR_RESP_SLVERR;
    localparam logic [11:0] F4 = `PFR_IDX_FLAGS4;
    localparam logic [11:0] F5 = `PFR_IDX_FLAGS5;
    localparam logic [11:0] F6 = `PFR_IDX_FLAGS6;
    localparam logic [11:0] SP1 = `PFR_IDX_SPORT1;
    localparam logic [11:0] M6 = `PFR_IDX_MASK6;

    logic clock, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    pfr_evt_t evt, e;
    pfr_lvl_t lvl;
    logic [7:0] g1, g2, sg, se, p2, p1;
    logic [11:0] regs [6];
    int n_fail = 0;
    int comparisons = 0;

    pfr_flags i_dut (.clock(clock), .nrst(nrst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .evt(evt), .lvl(lvl), .gen1_irq_sources(g1),
        .gen2_irq_sources(g2), .serial1_general_sources(sg),
        .serial1_error_sources(se), .sport2_irq_sources(p2),
        .sport1_irq_sources(p1), .irq(irq));

    pfr_periph_model i_per (.clock(clock), .evt(evt), .lvl(lvl), .gen1_src(g1),
        .gen2_src(g2), .ser1_gen(sg), .ser1_err(se), .sp2_src(p2), .sp1_src(p1));

    task automatic results;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tout;
        n_fail++;
        $display("wrong value at %0t: bus answer never came", $time);
        results();
    endtask

    // A leading edge keeps a release and the next request out of one time step
    task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [3:0] st,
                      input logic [1:0] er);
        logic aw_ok, w_ok;
        int n;
        aw_ok = 0;
        w_ok = 0;
        n = 0;
        @(posedge clock);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {24'h0, d};
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 40) begin
            @(posedge clock);
            n++;
            if (bvalid) break;
            if (!aw_ok && awready) begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end
        if (bvalid !== 1'b1) tout();
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic ar_ok;
        int n;
        ar_ok = 0;
        n = 0;
        @(posedge clock);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 40) begin
            @(posedge clock);
            n++;
            if (rvalid) break;
            if (!ar_ok && arready) begin
                ar_ok = 1;
                arvalid <= 1'b0;
            end
        end
        if (rvalid !== 1'b1) tout();
        rready <= 1'b0;
        check(rdata, {24'h0, d});
        check({30'h0, rresp}, {30'h0, er});
    endtask

    initial begin
        clock = 0;
        forever #20 clock = ~clock;
    end

    initial begin
        nrst = 0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        regs = '{F4, F5, F6, SP1, `PFR_IDX_MASK4, `PFR_IDX_MASK5};
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        foreach (regs[i]) rd(regs[i], 8'h00, OK);
        rd(M6, 8'h00, OK);
        rd(12'h4b5, 8'h00, ERR);
        wr(12'h4b5, 8'hff, 4'hf, ERR);
        // Every event with all masks off: flags set, no interrupt
        i_per.pulse('1);
        rd(F4, 8'h40, OK);
        rd(F5, 8'h70, OK);
        rd(F6, 8'hff, OK);
        check({31'h0, irq}, 32'h0);
        wr(F6, 8'h00, 4'h0, OK);
        rd(F6, 8'hff, OK);
        wr(F6, 8'h80, 4'h1, OK);
        rd(F6, 8'h80, OK);
        wr(F6, 8'h00, 4'h1, OK);
        rd(F6, 8'h00, OK);
        wr(F4, 8'hff, 4'h1, OK);
        rd(F4, 8'h40, OK);
        wr(F4, 8'h00, 4'h1, OK);
        rd(F4, 8'h00, OK);
        wr(F5, 8'h20, 4'h1, OK);
        rd(F5, 8'h20, OK);
        wr(F5, 8'h00, 4'h1, OK);
        rd(F5, 8'h00, OK);
        // Read-only bits follow the peripherals and ignore software
        i_per.set_src(8'h81, 8'h01, 8'h01, 8'h80, 8'h10, 8'h01, '1);
        rd(F4, 8'h8f, OK);
        rd(F5, 8'h87, OK);
        rd(SP1, 8'h07, OK);
        wr(F4, 8'h00, 4'h1, OK);
        wr(F5, 8'h00, 4'h1, OK);
        wr(SP1, 8'h00, 4'h1, OK);
        rd(F4, 8'h8f, OK);
        rd(F5, 8'h87, OK);
        rd(SP1, 8'h07, OK);
        i_per.set_src(8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, '0);
        rd(F4, 8'h80, OK);
        rd(F5, 8'h00, OK);
        rd(SP1, 8'h00, OK);
        i_per.set_src(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, '0);
        rd(F4, 8'h00, OK);
        // Flags are clear before the mask opens, so nothing fires at once
        rd(F6, 8'h00, OK);
        wr(M6, 8'h01, 4'h1, OK);
        rd(M6, 8'h01, OK);
        e = '0;
        e.osc1 = 1'b1;
        i_per.pulse(e);
        @(posedge clock);
        check({31'h0, irq}, 32'h0);
        e = '0;
        e.ext_irq1 = 1'b1;
        i_per.pulse(e);
        @(posedge clock);
        check({31'h0, irq}, 32'h1);
        wr(F6, 8'h00, 4'h1, OK);
        @(posedge clock);
        check({31'h0, irq}, 32'h0);
        wr(`PFR_IDX_MASK4, 8'h40, 4'h1, OK);
        rd(`PFR_IDX_MASK4, 8'h40, OK);
        e = '0;
        e.gen1_period = 1'b1;
        i_per.pulse(e);
        @(posedge clock);
        check({31'h0, irq}, 32'h1);
        wr(F4, 8'h00, 4'h1, OK);
        @(posedge clock);
        check({31'h0, irq}, 32'h0);
        results();
    end
endmodule
`default_nettype wire
